// file: rtl/rt_address_and_status_select.sv
// terminal address selection, command acceptance and status word sourcing
`timescale 1ns/1ps
`default_nettype none
// Operation
// - answer own-address command only when address matches and parity is odd
// - accept address 31 always unless broadcast disable bit is set
// - sample the programmed address about 2 us after command mid-parity
// - strobe low makes address and parity follow the pins directly
// - strobe rising edge captures pins; held value ignores later pin changes
// - extended, pin origin, latch-on-write: cfg5 write captures pins
// - extended, data origin, latch-on-write: cfg5 write loads D5-D1 and D0
// - cfg5 bit 6 reads the present strobe level
// - cfg5 reads internal address on bits 5-1, parity on bit 0
// - standard mode automates error, broadcast, bus control; busy, sreq, ssf from inverted cfg1 bits 10, 9, 8; zeros instr and reserved
// - standard mode sets optional terminal flag on next own-address reply after self-test fail
// - alternate mode takes eleven status bits from cfg1 bits 11-1
// - alternate mode only when extended and alternate bits are both set
// - command illegalization works in both status modes
// - cfg1 is sampled 4 to 5 us after command mid-parity
// - read-only register 0xe holds status of last own-address reply
// - alternate error bit follows cfg1 bit 11, forced on illegal command
module rt_address_and_status_select #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic addressLatchStrobe,
    input wire logic [4:0] terminalAddressPins,
    input wire logic terminalAddressParityPin,
    input wire logic cmdValid,
    input wire rt_sel_pkg::cmd_s cmdWord,
    input wire logic cmdIllegal,
    input wire logic cmdDynBusCtrl,
    input wire logic dataWordError,
    input wire logic selfTestFail,
    output logic cmdAccept,
    output logic cmdBroadcast,
    output logic respValid,
    output rt_sel_pkg::status_s respStatus
);
    typedef enum logic [1:0] {IDLE, ADDR_WAIT, CFG_WAIT} seq_e;

    function automatic logic oddParity(input logic [5:0] v);
        oddParity = ^v;
    endfunction : oddParity

    function automatic logic mapped(input logic [3:0] idx);
        mapped = idx == rt_sel_pkg::IDX_CFG1 || idx == rt_sel_pkg::IDX_CFG3
            || idx == rt_sel_pkg::IDX_CFG4 || idx == rt_sel_pkg::IDX_CFG5
            || idx == rt_sel_pkg::IDX_CFG6
            || idx == rt_sel_pkg::IDX_LAST_STATUS;
    endfunction : mapped

    logic [15:0] cfg1_r;
    logic [15:0] cfg3_r;
    logic [15:0] cfg4_r;
    logic [15:0] cfg6_r;
    logic bcstDisable_r;
    logic [15:0] lastStatus_r;
    logic readyR;
    logic errR;
    logic [31:0] prdata_r;
    logic access;
    logic wrEn;
    logic [3:0] idx;
    logic idxOk;
    logic [15:0] cfg5View;
    logic extMode;
    logic altMode;
    logic swCapture;
    logic [4:0] intAddr;
    logic intParity;

    seq_e seq_r;
    logic [15:0] seqCnt_r;
    rt_sel_pkg::cmd_s cmd_r;
    logic illegal_r;
    logic dbcCmd_r;
    logic ours_r;
    logic isBcst_r;
    logic decide;
    logic matchOwn;
    logic matchBcst;
    logic build;
    logic merrPend_r;
    logic bcstSeen_r;
    logic tflagPend_r;
    logic cmdAccept_r;
    logic cmdBroadcast_r;
    logic respValid_r;
    rt_sel_pkg::status_s respStatus_r;
    rt_sel_pkg::status_s built;
    rt_sel_pkg::auto_s autoFlags;

    // apb: one wait state so read data leaves a flip-flop
    assign access = psel && penable;
    assign idx = paddr[5:2];
    assign idxOk = paddr[1:0] == 2'b00 && paddr[ADDR_W-1:6] == '0
        && mapped(idx);
    assign wrEn = access && readyR && pwrite && idxOk;
    assign pready = readyR;
    assign pslverr = readyR && errR;
    assign prdata = prdata_r;

    always_ff @(posedge mclk)
        if (!resetn)
            readyR <= 1'b0;
        else
            readyR <= access && !readyR;

    always_ff @(posedge mclk)
        if (!resetn)
            errR <= 1'b0;
        else if (access && !readyR)
            errR <= !idxOk || (pwrite && idx == rt_sel_pkg::IDX_LAST_STATUS);

    assign cfg5View = {8'h00, bcstDisable_r, addressLatchStrobe,
                       intAddr, intParity};

    always_ff @(posedge mclk)
        if (!resetn)
            prdata_r <= 32'h00000000;
        else if (access && !readyR && !pwrite)
        begin
            unique case (idx)
                rt_sel_pkg::IDX_CFG1: prdata_r <= {16'h0000, cfg1_r};
                rt_sel_pkg::IDX_CFG3: prdata_r <= {16'h0000, cfg3_r};
                rt_sel_pkg::IDX_CFG4: prdata_r <= {16'h0000, cfg4_r};
                rt_sel_pkg::IDX_CFG5: prdata_r <= {16'h0000, cfg5View};
                rt_sel_pkg::IDX_CFG6: prdata_r <= {16'h0000, cfg6_r};
                rt_sel_pkg::IDX_LAST_STATUS:
                    prdata_r <= {16'h0000, lastStatus_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end

    always_ff @(posedge mclk)
        if (!resetn)
        begin
            cfg1_r <= rt_sel_pkg::CFG1_RST;
            cfg3_r <= rt_sel_pkg::CFG3_RST;
            cfg4_r <= rt_sel_pkg::CFG4_RST;
            cfg6_r <= rt_sel_pkg::CFG6_RST;
        end
        else if (wrEn)
        begin
            if (idx == rt_sel_pkg::IDX_CFG1)
                cfg1_r <= pwdata[15:0];
            if (idx == rt_sel_pkg::IDX_CFG3)
                cfg3_r <= pwdata[15:0];
            if (idx == rt_sel_pkg::IDX_CFG4)
                cfg4_r <= pwdata[15:0];
            if (idx == rt_sel_pkg::IDX_CFG6)
                cfg6_r <= pwdata[15:0];
        end

    // broadcast disable is the only stored bit of cfg5
    always_ff @(posedge mclk)
        if (!resetn)
            bcstDisable_r <= rt_sel_pkg::BCST_DIS_RST;
        else if (wrEn && idx == rt_sel_pkg::IDX_CFG5)
            bcstDisable_r <= pwdata[rt_sel_pkg::CFG5_BCST_DIS_BIT];

    assign extMode = cfg3_r[rt_sel_pkg::CFG3_EXT_BIT];
    assign altMode = extMode && cfg3_r[rt_sel_pkg::CFG3_ALT_BIT];
    // software should drop latch-on-write afterwards, else every cfg5
    // write moves the address again
    assign swCapture = wrEn && idx == rt_sel_pkg::IDX_CFG5
        && addressLatchStrobe && extMode
        && cfg4_r[rt_sel_pkg::CFG4_LATCH_BIT];

    rt_addr_latch u_addr (
        .mclk(mclk),
        .resetn(resetn),
        .addressLatchStrobe(addressLatchStrobe),
        .terminalAddressPins(terminalAddressPins),
        .terminalAddressParityPin(terminalAddressParityPin),
        .swCapture(swCapture),
        .addressOriginSelect(cfg6_r[rt_sel_pkg::CFG6_ORIGIN_BIT]),
        .swData(pwdata[5:0]),
        .intAddr(intAddr),
        .intParity(intParity)
    );

    // command timing; a fresh command restarts the sequence
    assign decide = seq_r == ADDR_WAIT
        && seqCnt_r == 16'(rt_sel_pkg::ADDR_SAMPLE_CYC - 1);
    assign build = seq_r == CFG_WAIT
        && seqCnt_r == 16'(rt_sel_pkg::CFG_SAMPLE_CYC - 1);
    assign matchOwn = cmd_r.addr == intAddr
        && oddParity({intAddr, intParity});
    assign matchBcst = cmd_r.addr == rt_sel_pkg::BCAST_ADDR
        && !bcstDisable_r;

    always_ff @(posedge mclk)
        if (!resetn)
            seq_r <= IDLE;
        else if (cmdValid)
            seq_r <= ADDR_WAIT;
        else
        begin
            unique case (seq_r)
                IDLE: seq_r <= IDLE;
                ADDR_WAIT:
                    if (decide)
                        seq_r <= (matchOwn || matchBcst) ? CFG_WAIT : IDLE;
                CFG_WAIT:
                    if (build)
                        seq_r <= IDLE;
            endcase
        end

    always_ff @(posedge mclk)
        if (!resetn)
            seqCnt_r <= 16'h0000;
        else if (cmdValid || seq_r == IDLE)
            seqCnt_r <= 16'h0000;
        else
            seqCnt_r <= seqCnt_r + 16'h0001;

    always_ff @(posedge mclk)
        if (!resetn)
        begin
            cmd_r <= '0;
            illegal_r <= 1'b0;
            dbcCmd_r <= 1'b0;
        end
        else if (cmdValid)
        begin
            cmd_r <= cmdWord;
            illegal_r <= cmdIllegal;
            dbcCmd_r <= cmdDynBusCtrl;
        end

    // broadcast wins over own match when the address is 31 and not disabled
    always_ff @(posedge mclk)
        if (!resetn)
        begin
            ours_r <= 1'b0;
            isBcst_r <= 1'b0;
        end
        else if (decide)
        begin
            ours_r <= matchOwn && !matchBcst;
            isBcst_r <= matchBcst;
        end

    always_ff @(posedge mclk)
        if (!resetn)
        begin
            cmdAccept_r <= 1'b0;
            cmdBroadcast_r <= 1'b0;
        end
        else
        begin
            cmdAccept_r <= decide && (matchOwn || matchBcst);
            cmdBroadcast_r <= decide && matchBcst;
        end

    assign cmdAccept = cmdAccept_r;
    assign cmdBroadcast = cmdBroadcast_r;

    // sticky auto flags: a new event wins over the clear by a reply
    always_ff @(posedge mclk)
        if (!resetn)
            merrPend_r <= 1'b0;
        else if (dataWordError)
            merrPend_r <= 1'b1;
        else if (build && ours_r)
            merrPend_r <= 1'b0;

    always_ff @(posedge mclk)
        if (!resetn)
            bcstSeen_r <= 1'b0;
        else if (build && isBcst_r)
            bcstSeen_r <= 1'b1;
        else if (build && ours_r)
            bcstSeen_r <= 1'b0;

    always_ff @(posedge mclk)
        if (!resetn)
            tflagPend_r <= 1'b0;
        else if (selfTestFail && cfg6_r[rt_sel_pkg::CFG6_TFLAG_OPT_BIT])
            tflagPend_r <= 1'b1;
        else if (build && ours_r)
            tflagPend_r <= 1'b0;

    assign autoFlags.merr = merrPend_r;
    assign autoFlags.bcst = bcstSeen_r;
    assign autoFlags.dbca = dbcCmd_r && !cfg1_r[rt_sel_pkg::CFG1_DBCA_N_BIT];
    assign autoFlags.tflag = tflagPend_r;

    rt_status_build u_status (
        .mclk(mclk),
        .resetn(resetn),
        .altMode(altMode),
        .cfg1(cfg1_r),
        .cmdIllegal(illegal_r),
        .autoFlags(autoFlags),
        .addr(intAddr),
        .status(built)
    );

    // cfg1 is taken only at the build instant
    always_ff @(posedge mclk)
        if (!resetn)
        begin
            respValid_r <= 1'b0;
            respStatus_r <= '0;
        end
        else
        begin
            respValid_r <= build && ours_r;
            if (build && ours_r)
                respStatus_r <= built;
        end

    assign respValid = respValid_r;
    assign respStatus = respStatus_r;

    always_ff @(posedge mclk)
        if (!resetn)
            lastStatus_r <= 16'h0000;
        else if (build && ours_r)
            lastStatus_r <= built;

    own_match_a: assert property (@(posedge mclk) disable iff (!resetn)
        decide && !matchBcst && cmd_r.addr == intAddr
            && !oddParity({intAddr, intParity}) |=> !cmdAccept)
        else $error("accepted command with even address parity");
    bcast_take_a: assert property (@(posedge mclk) disable iff (!resetn)
        decide && cmd_r.addr == rt_sel_pkg::BCAST_ADDR
            |=> cmdBroadcast == !$past(bcstDisable_r))
        else $error("broadcast acceptance wrong");
    addr_time_a: assert property (@(posedge mclk) disable iff (!resetn)
        cmdAccept |-> $past(seqCnt_r) ==
            16'(rt_sel_pkg::ADDR_SAMPLE_CYC - 1))
        else $error("address sampled at wrong time");
    strobe_read_a: assert property (@(posedge mclk) disable iff (!resetn)
        access && !readyR && !pwrite && idx == rt_sel_pkg::IDX_CFG5
            && idxOk |=> prdata[6] == $past(addressLatchStrobe)
            && prdata[5:0] == $past({intAddr, intParity}))
        else $error("cfg5 readback wrong");
    mode_sel_a: assert property (@(posedge mclk) disable iff (!resetn)
        altMode == (cfg3_r[15] && cfg3_r[5]))
        else $error("status mode select wrong");
    last_status_a: assert property (@(posedge mclk) disable iff (!resetn)
        respValid |-> lastStatus_r == respStatus)
        else $error("last status register not updated");
    reset_ctrl_a: assert property (@(posedge mclk)
        !resetn |=> cfg3_r == 16'h0000 && cfg4_r == 16'h0000
            && cfg6_r == 16'h0000)
        else $error("controls not cleared by reset");
    cfg_time_a: assert property (@(posedge mclk) disable iff (!resetn)
        respValid |-> $past(seqCnt_r) ==
            16'(rt_sel_pkg::CFG_SAMPLE_CYC - 1))
        else $error("cfg1 sampled at wrong time");
endmodule : rt_address_and_status_select
`default_nettype wire

// file: rtl/rt_sel_pkg.sv
// package: register map, field positions, timing and carriers for rt select
package rt_sel_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned ADDR_SAMPLE_NS = 2000;
    localparam int unsigned CFG_SAMPLE_NS = 4000;
    // address taken at 2 us; cfg1 taken as its 4 us window opens
    localparam int unsigned ADDR_SAMPLE_CYC = ADDR_SAMPLE_NS / CLK_PERIOD_NS;
    localparam int unsigned CFG_SAMPLE_CYC =
        (CFG_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CFG1 = 4'h1;
    localparam logic [3:0] IDX_CFG3 = 4'h3;
    localparam logic [3:0] IDX_CFG4 = 4'h4;
    localparam logic [3:0] IDX_CFG5 = 4'h5;
    localparam logic [3:0] IDX_CFG6 = 4'h6;
    localparam logic [3:0] IDX_LAST_STATUS = 4'he;

    localparam logic [15:0] CFG1_RST = 16'h0000;
    localparam logic [15:0] CFG3_RST = 16'h0000;
    localparam logic [15:0] CFG4_RST = 16'h0000;
    localparam logic [15:0] CFG6_RST = 16'h0000;
    localparam logic BCST_DIS_RST = 1'b0;

    localparam int unsigned CFG3_EXT_BIT = 15;
    localparam int unsigned CFG3_ALT_BIT = 5;
    localparam int unsigned CFG4_LATCH_BIT = 3;
    localparam int unsigned CFG5_BCST_DIS_BIT = 7;
    localparam int unsigned CFG5_STROBE_BIT = 6;
    localparam int unsigned CFG6_ORIGIN_BIT = 5;
    localparam int unsigned CFG6_TFLAG_OPT_BIT = 0;
    localparam int unsigned CFG1_DBCA_N_BIT = 11;
    localparam int unsigned CFG1_BUSY_N_BIT = 10;
    localparam int unsigned CFG1_SREQ_N_BIT = 9;
    localparam int unsigned CFG1_SSF_N_BIT = 8;

    localparam logic [4:0] BCAST_ADDR = 5'h1f;

    typedef struct packed {
        logic [4:0] addr;
        logic tr;
        logic [4:0] sub;
        logic [4:0] cnt;
    } cmd_s;

    typedef struct packed {
        logic [4:0] addr;
        logic merr;
        logic instr;
        logic sreq;
        logic [2:0] rsv;
        logic bcst;
        logic busy;
        logic ssf;
        logic dbca;
        logic tflag;
    } status_s;

    typedef struct packed {
        logic merr;
        logic bcst;
        logic dbca;
        logic tflag;
    } auto_s;
endpackage : rt_sel_pkg

// file: rtl/rt_addr_latch.sv
// terminal address source: transparent, strobe latched or software captured
`timescale 1ns/1ps
`default_nettype none
module rt_addr_latch (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic addressLatchStrobe,
    input wire logic [4:0] terminalAddressPins,
    input wire logic terminalAddressParityPin,
    input wire logic swCapture,
    input wire logic addressOriginSelect,
    input wire logic [5:0] swData,
    output logic [4:0] intAddr,
    output logic intParity
);
    logic strobePrev_r;
    logic [5:0] held_r;

    always_ff @(posedge mclk)
        if (!resetn)
            strobePrev_r <= 1'b0;
        else
            strobePrev_r <= addressLatchStrobe;

    always_ff @(posedge mclk)
        if (!resetn)
            held_r <= 6'h00;
        else if (addressLatchStrobe && !strobePrev_r)
            held_r <= {terminalAddressPins, terminalAddressParityPin};
        else if (swCapture && !addressOriginSelect)
            held_r <= {terminalAddressPins, terminalAddressParityPin};
        else if (swCapture)
            held_r <= swData;

    // strobe tied low means pins flow straight through
    assign intAddr = addressLatchStrobe ? held_r[5:1] : terminalAddressPins;
    assign intParity = addressLatchStrobe ? held_r[0]
                                          : terminalAddressParityPin;

    transparent_a: assert property (@(posedge mclk) disable iff (!resetn)
        !addressLatchStrobe |-> intAddr == terminalAddressPins
            && intParity == terminalAddressParityPin)
        else $error("address not transparent with strobe low");
    latch_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        addressLatchStrobe && $past(addressLatchStrobe)
            && $past(strobePrev_r) && !$past(swCapture)
            |-> $stable({intAddr, intParity}))
        else $error("latched address moved without capture");
    pin_capture_a: assert property (@(posedge mclk) disable iff (!resetn)
        swCapture && !addressOriginSelect && addressLatchStrobe
            ##1 addressLatchStrobe |-> {intAddr, intParity} ==
            $past({terminalAddressPins, terminalAddressParityPin}))
        else $error("software pin capture lost");
    data_capture_a: assert property (@(posedge mclk) disable iff (!resetn)
        swCapture && addressOriginSelect && $past(addressLatchStrobe)
            && addressLatchStrobe ##1 addressLatchStrobe
            |-> {intAddr, intParity} == $past(swData))
        else $error("software data capture lost");
endmodule : rt_addr_latch
`default_nettype wire

// file: rtl/rt_status_build.sv
// status word assembly in standard or host-programmed mode
`timescale 1ns/1ps
`default_nettype none
module rt_status_build (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic altMode,
    input wire logic [15:0] cfg1,
    input wire logic cmdIllegal,
    input wire rt_sel_pkg::auto_s autoFlags,
    input wire logic [4:0] addr,
    output rt_sel_pkg::status_s status
);
    always_comb
    begin
        status = '0;
        status.addr = addr;
        if (altMode)
        begin
            // all eleven bits from cfg1[11:1]; merr is then also set by cmdIllegal
            {status.merr, status.instr, status.sreq, status.rsv, status.bcst,
             status.busy, status.ssf, status.dbca, status.tflag} =
                cfg1[11:1];
            status.merr = cfg1[11] | cmdIllegal;
        end
        else
        begin
            status.merr = autoFlags.merr | cmdIllegal;
            status.bcst = autoFlags.bcst;
            status.dbca = autoFlags.dbca;
            status.busy = !cfg1[rt_sel_pkg::CFG1_BUSY_N_BIT];
            status.sreq = !cfg1[rt_sel_pkg::CFG1_SREQ_N_BIT];
            status.ssf = !cfg1[rt_sel_pkg::CFG1_SSF_N_BIT];
            status.tflag = autoFlags.tflag;
        end
    end

    std_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
        !altMode |-> !status.instr && status.rsv == 3'h0
            && status.merr == (autoFlags.merr | cmdIllegal))
        else $error("standard status carries host-only bits");
    alt_map_a: assert property (@(posedge mclk) disable iff (!resetn)
        altMode |-> status.busy == cfg1[4]
            && status.merr == (cfg1[11] | cmdIllegal))
        else $error("alternate status not taken from cfg1");
endmodule : rt_status_build
`default_nettype wire

// file: tb/bc_model.sv
// bus controller model: issues one command word per request
`timescale 1ns/1ps
`default_nettype none
module bc_model (
    input wire logic mclk,
    input wire logic go,
    input wire rt_sel_pkg::cmd_s cmdIn,
    input wire logic illIn,
    input wire logic dynIn,
    output logic cmdValid,
    output rt_sel_pkg::cmd_s cmdWord,
    output logic cmdIllegal,
    output logic cmdDyn
);
    always_ff @(posedge mclk)
    begin
        cmdValid <= go;
        // word means nothing off the pulse; show garbage, not the last value
        cmdWord <= go ? cmdIn : ~cmdIn;
        cmdIllegal <= go ? illIn : ~illIn;
        cmdDyn <= go ? dynIn : ~dynIn;
    end
endmodule : bc_model
`default_nettype wire

// file: tb/rt_address_and_status_select_tb.sv
// bench: address selection and status sourcing against a model
`timescale 1ns/1ps
`default_nettype none
module rt_address_and_status_select_tb;
    logic mclk = 1'b0, resetn = 1'b0, stb = 1'b0, pinPar = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0] pins = 5'h00, mA = 5'h00;
    logic go = 1'b0, ill = 1'b0, dyn = 1'b0, dwErr = 1'b0, stFail = 1'b0;
    rt_sel_pkg::cmd_s cmdIn = '0, cmdWord;
    rt_sel_pkg::status_s sts;
    logic pready, pslverr, cmdValid, cmdIllegal, cmdDyn, er;
    logic acc, bc, rv, mP = 1'b1, alt = 1'b0, bcP = 1'b0, meP = 1'b0;
    logic tfP = 1'b0, bcD = 1'b0;
    logic [15:0] c1 = 16'h0;
    int errCount = 0, totalChecks = 0, cyc = 0;
    rt_address_and_status_select dut (.mclk(mclk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addressLatchStrobe(stb),
        .terminalAddressPins(pins), .terminalAddressParityPin(pinPar),
        .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdIllegal(cmdIllegal),
        .cmdDynBusCtrl(cmdDyn), .dataWordError(dwErr),
        .selfTestFail(stFail), .cmdAccept(acc), .cmdBroadcast(bc),
        .respValid(rv), .respStatus(sts));
    bc_model bc0 (.mclk(mclk), .go(go), .cmdIn(cmdIn), .illIn(ill),
        .dynIn(dyn), .cmdValid(cmdValid), .cmdWord(cmdWord),
        .cmdIllegal(cmdIllegal), .cmdDyn(cmdDyn));
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic stopTest();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stopTest
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errCount++;
            stopTest();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [3:0] i, input int d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // no retry limit: the run-wide cycle ceiling ends a hung wait
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic pinSet(input logic [4:0] a, input logic p);
        pins <= a;
        pinPar <= p;
        repeat (3) @(posedge mclk);
        if (!stb)
            {mA, mP} = {a, p};
    endtask : pinSet
    task automatic rd5();
        apb(1'b0, rt_sel_pkg::IDX_CFG5, 0);
        chk(rd, {24'h0, bcD, stb, mA, mP});
    endtask : rd5
    task automatic cmd(input logic [4:0] a, input logic il, input logic dy);
        logic sa, sb, sr, bcs, own;
        rt_sel_pkg::status_s got, exp;
        bcs = a == rt_sel_pkg::BCAST_ADDR && !bcD;
        own = !bcs && a == mA && (^{mA, mP});
        cmdIn <= {a, 1'b0, 5'h01, 5'h02};
        {ill, dyn, go} <= {il, dy, 1'b1};
        @(posedge mclk);
        go <= 1'b0;
        {sa, sb, sr} = 3'b000;
        repeat (1300)
        begin
            @(posedge mclk);
            sa |= acc === 1'b1;
            sb |= bc === 1'b1;
            if (rv === 1'b1)
                {sr, got} = {1'b1, sts};
        end
        if (alt)
            exp = {a, c1[11] | il, c1[10:1]};
        else
            exp = {a, meP | il, 1'b0, ~c1[9], 3'b000, bcP, ~c1[10],
                ~c1[8], dy & ~c1[11], tfP};
        chk(sa, own | bcs);
        chk(sb, bcs);
        chk(sr, own);
        if (own)
        begin
            chk(got, exp);
            apb(1'b0, rt_sel_pkg::IDX_LAST_STATUS, 0);
            chk(rd, exp);
            {bcP, meP, tfP} = 3'b000;
        end
        bcP |= bcs;
    endtask : cmd
    initial
    begin
        logic [4:0] a;
        void'($urandom(32'hf317));
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, rt_sel_pkg::IDX_CFG3, 0);
        chk(rd, 0);
        pinSet(5'h05, ~^5'h05);
        rd5();
        c1 = {4'h0, 4'($urandom), 8'h00};
        apb(1'b1, rt_sel_pkg::IDX_CFG1, c1);
        cmd(5'h05, 1'b0, 1'b1);
        cmd(5'h05, 1'b1, 1'b0);
        pinSet(5'h09, ^5'h09);
        cmd(5'h09, 1'b0, 1'b0);
        $display("test transparent done");
        pinSet(5'h0c, ~^5'h0c);
        cmd(5'h1f, 1'b0, 1'b0);
        apb(1'b1, rt_sel_pkg::IDX_CFG6, 1);
        {dwErr, stFail} <= 2'b11;
        @(posedge mclk);
        {dwErr, stFail} <= 2'b00;
        {meP, tfP} = 2'b11;
        cmd(5'h0c, 1'b0, 1'b0);
        apb(1'b1, rt_sel_pkg::IDX_CFG5, 32'h80);
        bcD = 1'b1;
        rd5();
        cmd(5'h1f, 1'b0, 1'b0);
        apb(1'b1, rt_sel_pkg::IDX_CFG5, 0);
        bcD = 1'b0;
        $display("test broadcast done");
        pinSet(5'h03, ~^5'h03);
        stb <= 1'b1;
        @(posedge mclk);
        // pins move after the strobe edge; the held address must not
        pinSet(5'h1a, 1'b0);
        rd5();
        cmd(5'h03, 1'b0, 1'b0);
        apb(1'b1, rt_sel_pkg::IDX_CFG3, 32'h8000);
        apb(1'b1, rt_sel_pkg::IDX_CFG4, 32'h0008);
        apb(1'b1, rt_sel_pkg::IDX_CFG6, 0);
        apb(1'b1, rt_sel_pkg::IDX_CFG5, 32'h3f);
        {mA, mP} = {5'h1a, 1'b0};
        rd5();
        apb(1'b1, rt_sel_pkg::IDX_CFG6, 32'h20);
        // keep clear of the broadcast address so the mode tests get replies
        a = 5'($urandom % 31);
        apb(1'b1, rt_sel_pkg::IDX_CFG5, {a, ~^a});
        {mA, mP} = {a, ~^a};
        rd5();
        apb(1'b1, rt_sel_pkg::IDX_CFG4, 0);
        apb(1'b1, rt_sel_pkg::IDX_CFG5, {~a, ^a});
        rd5();
        $display("test capture done");
        c1 = 16'($urandom) & 16'h0ffe;
        apb(1'b1, rt_sel_pkg::IDX_CFG1, c1);
        apb(1'b1, rt_sel_pkg::IDX_CFG3, 32'h8020);
        alt = 1'b1;
        cmd(mA, 1'b0, 1'b0);
        cmd(mA, 1'b1, 1'b0);
        apb(1'b1, rt_sel_pkg::IDX_CFG3, 32'h0020);
        alt = 1'b0;
        cmd(mA, 1'b0, 1'b0);
        apb(1'b0, 4'h2, 0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, rt_sel_pkg::IDX_LAST_STATUS, 0);
        chk(er, 1'b1);
        $display("test modes done");
        stopTest();
    end
endmodule : rt_address_and_status_select_tb
`default_nettype wire
